/* sepa_defs.vh */
// Constants for the serial EEPROM page-access block
`ifndef SEPA_DEFS_VH
`define SEPA_DEFS_VH
`define SEPA_OP_SETWEL    8'h06
`define SEPA_OP_CLRWEL    8'h04
`define SEPA_OP_RDSTAT    8'h05
`define SEPA_OP_WRSTAT    8'h01
`define SEPA_OP_READ      8'h03
`define SEPA_OP_WRITE     8'h02
`define SEPA_OP_MASK      8'hf7
`define SEPA_ADDR_W       17
`define SEPA_PAGE_W       7
`define SEPA_ST_PEN       7
`define SEPA_ST_BPH       3
`define SEPA_ST_BPL       2
`define SEPA_ST_WEL       1
`define SEPA_ST_BUSY      0
`define SEPA_BP_QUARTER   17'h18000
`define SEPA_BP_HALF      17'h10000
`define SEPA_TWC_NS       5000000
`define SEPA_CLK_NS       25
`define SEPA_TWC_CYC      ((`SEPA_TWC_NS + `SEPA_CLK_NS - 1) / `SEPA_CLK_NS)
`endif

/* sepa_mem.v */
// Byte-wide array memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sepa_mem #(
    parameter AW = 17
) (
    input  wire          ref_clk,
    input  wire          ce,
    input  wire          set_write_latch_cmd,
    input  wire [AW-1:0] wrAddr,
    input  wire [7:0]    wrData,
    input  wire [AW-1:0] rdAddr,
    output reg  [7:0]    rdData_ff
);
    reg [7:0] mem [0:(1<<AW)-1];

    // Single write port, registered read port
    always @(posedge ref_clk) begin
        if (ce) begin
            if (set_write_latch_cmd) begin
                mem[wrAddr] <= wrData;
            end
            rdData_ff <= mem[rdAddr];
        end
    end
endmodule // sepa_mem
`default_nettype wire

/* sepa_top.v */
// SPI serial EEPROM command decode, page buffer and array access
//
// Behaviour
// RULE_01 - Protected blocks never written; status writable only if pin high or enable clear, latch set.
// RULE_02 - Master lowers select, then sends read opcode and address.
// RULE_03 - After read address, serial input is ignored until select rises.
// RULE_04 - Stored byte at address goes out bit 7 first.
// RULE_05 - Single-byte reader raises select after eighth data bit.
// RULE_06 - Address increments after each byte while select stays low.
// RULE_07 - Read address wraps from top of array to zero.
// RULE_08 - Three address bytes; only bits 16..0 used.
// RULE_09 - Master sends set-latch command as separate frame before each write.
// RULE_10 - Only locations outside block-protect range get programmed.
// RULE_11 - During internal write only status read is accepted.
// RULE_12 - Write is opcode, address, data; programming starts when select rises.
// RULE_13 - Master raises select in clock low phase after a byte's bit 0.
// RULE_14 - Status bit 0 is 1 while write in progress, else 0.
// RULE_15 - Master sends exactly 128 data bytes per page write.
// RULE_16 - Only low seven address bits increment per data byte.
// RULE_17 - Beyond 128 bytes the in-page address wraps and overwrites.
// RULE_18 - Write-enable latch clears at end of every internal write.
// RULE_19 - Write with latch clear is discarded when select rises.
// RULE_20 - A new select falling edge is needed before next command.
// RULE_21 - Eight-bit opcodes, bit 3 ignored.
// RULE_22 - Everything MSB first; commands begin on select falling edge.
// RULE_23 - Status: enable bit7, protect bits 3..2, latch bit1, busy bit0; all ones busy.
// RULE_24 - Protect levels: none, top quarter, top half, whole array.
// RULE_25 - Input sampled on rising clock, output changes on falling clock.
`timescale 1ns/1ps
`default_nettype none
`include "sepa_defs.vh"
module sepa_top #(
    parameter TWC_CYC = `SEPA_TWC_CYC
) (
    input  wire ref_clk,
    input  wire rst_b,
    input  wire ce,
    input  wire spiCsB,
    input  wire spiSck,
    input  wire spiSi,
    input  wire protectPinB,
    output reg  spiSo_ff,
    output wire spiSoOeB,
    output wire busy
);
    localparam AW = `SEPA_ADDR_W;
    localparam PW = `SEPA_PAGE_W;
    localparam S_IDLE = 6'h01, S_ADDR = 6'h02, S_RDAT = 6'h04, S_WDAT = 6'h08, S_STAT = 6'h10, S_DEAD = 6'h20;
    localparam P_IDLE = 3'h1, P_PROG = 3'h2, P_WAIT = 3'h4;

    // Three-stage synchronisers; a select or clock change counts when stages 2 and 3 agree
    reg [2:0] csSync_ff, sckSync_ff, siSync_ff, wpSync_ff;
    reg       csSt_ff, sckSt_ff;
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            csSync_ff  <= 3'h7;
            sckSync_ff <= 3'h0;
            siSync_ff  <= 3'h0;
            wpSync_ff  <= 3'h7;
            csSt_ff    <= 1'b1;
            sckSt_ff   <= 1'b0;
        end else if (ce) begin
            csSync_ff  <= {csSync_ff[1:0], spiCsB};
            sckSync_ff <= {sckSync_ff[1:0], spiSck};
            siSync_ff  <= {siSync_ff[1:0], spiSi};
            wpSync_ff  <= {wpSync_ff[1:0], protectPinB};
            if (csSync_ff[1] == csSync_ff[2]) csSt_ff <= csSync_ff[2];
            if (sckSync_ff[1] == sckSync_ff[2]) sckSt_ff <= sckSync_ff[2];
        end
    end
    wire csFall = csSt_ff & (csSync_ff[1] == csSync_ff[2]) & ~csSync_ff[2];
    wire csRise = ~csSt_ff & (csSync_ff[1] == csSync_ff[2]) & csSync_ff[2];
    wire sel    = ~csSt_ff & ~csRise;
    wire sckRise = sel & ~sckSt_ff & (sckSync_ff[1] == sckSync_ff[2]) & sckSync_ff[2];   // RULE_25
    wire sckFall = sel & sckSt_ff & (sckSync_ff[1] == sckSync_ff[2]) & ~sckSync_ff[2];   // RULE_25
    wire siBit  = siSync_ff[2];
    wire wpHigh = wpSync_ff[2];

    // Protocol state
    reg [5:0]    st_ff;
    reg [2:0]    pst_ff;
    reg [7:0]    sh_ff;
    reg [2:0]    bitCnt_ff;
    reg [1:0]    byteCnt_ff;
    reg [7:0]    op_ff;
    reg [AW-1:0] addr_ff;
    reg [7:0]    txByte_ff;
    reg          loadTx_ff;
    reg          wel_ff, pen_ff, bph_ff, bpl_ff;
    reg [7:0]    page_ff [0:(1<<PW)-1];
    reg [PW:0]   progIdx_ff;
    reg [31:0]   twc_ff;
    reg          wrPend_ff, stPend_ff;
    reg [7:0]    stNew_ff;
    wire [7:0]   memRd;

    assign busy = (pst_ff != P_IDLE);
    wire [7:0] statusByte = busy ? 8'hff :                                               // RULE_23
        {pen_ff, 3'h0, bph_ff, bpl_ff, wel_ff, 1'b0};                                    // RULE_14
    wire [7:0] byteIn  = {sh_ff[6:0], siBit};                                            // RULE_22
    wire [7:0] opMask  = byteIn & `SEPA_OP_MASK;                                         // RULE_21
    wire       byteEnd = sckRise & (bitCnt_ff == 3'h7);
    wire       dataSeen = (st_ff == S_WDAT) & (byteCnt_ff != 2'h0);
    wire [AW-1:0] progAddr = {addr_ff[AW-1:PW], progIdx_ff[PW-1:0]};
    // Protection level compare
    wire inProt = ({bph_ff, bpl_ff} == 2'h3) |
                  ({bph_ff, bpl_ff} == 2'h2 && progAddr >= `SEPA_BP_HALF) |
                  ({bph_ff, bpl_ff} == 2'h1 && progAddr >= `SEPA_BP_QUARTER);            // RULE_24
    wire memWe = (pst_ff == P_PROG) & ~inProt;                                           // RULE_10 RULE_01
    wire stWrOk = wel_ff & (wpHigh | ~pen_ff);                                           // RULE_01
    wire [AW-1:0] rdAddr = (st_ff == S_ADDR) ? {addr_ff[AW-9:0], byteIn} : addr_ff + 1'b1;

    sepa_mem #(.AW(AW)) u_mem (
        .ref_clk   (ref_clk),
        .ce        (ce),
        .set_write_latch_cmd      (memWe),
        .wrAddr    (progAddr),
        .wrData    (page_ff[progIdx_ff[PW-1:0]]),
        .rdAddr    (rdAddr),
        .rdData_ff (memRd)
    );

    // Serial output released (oe high) except while shifting read or status data
    assign spiSoOeB = ~(sel & ((st_ff == S_RDAT) | (st_ff == S_STAT)));

    // Command decode, address and data shifting
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            st_ff <= S_IDLE; sh_ff <= 8'h00; bitCnt_ff <= 3'h0; byteCnt_ff <= 2'h0;
            op_ff <= 8'h00; addr_ff <= {AW{1'b0}}; txByte_ff <= 8'h00; loadTx_ff <= 1'b0;
            spiSo_ff <= 1'b0; wrPend_ff <= 1'b0; stPend_ff <= 1'b0; stNew_ff <= 8'h00;
        end else if (ce) begin
            wrPend_ff <= 1'b0;
            stPend_ff <= 1'b0;
            if (loadTx_ff) begin
                txByte_ff <= memRd;
                loadTx_ff <= 1'b0;
            end
            if (csFall) begin                                                            // RULE_22 RULE_20
                st_ff <= S_ADDR; bitCnt_ff <= 3'h0; byteCnt_ff <= 2'h0; op_ff <= 8'h00;
            end else if (csRise) begin
                // Programming only begins on the closing select edge
                if (dataSeen && wel_ff && op_ff == `SEPA_OP_WRITE) wrPend_ff <= 1'b1;     // RULE_12 RULE_19
                // Pin and latch judged at the closing edge, so a pin drop mid-frame still blocks it
                if (dataSeen && stWrOk && op_ff == `SEPA_OP_WRSTAT) stPend_ff <= 1'b1;    // RULE_01 RULE_12
                st_ff <= S_IDLE;
            end else if (sckRise) begin
                sh_ff <= byteIn;
                bitCnt_ff <= bitCnt_ff + 3'h1;
                if (byteEnd) begin
                    case (st_ff)
                        S_ADDR: begin
                            if (op_ff == 8'h00) begin
                                op_ff <= opMask;
                                if (busy && opMask != `SEPA_OP_RDSTAT) st_ff <= S_DEAD;  // RULE_11
                                else if (opMask == `SEPA_OP_RDSTAT) begin
                                    st_ff <= S_STAT; txByte_ff <= statusByte;
                                end else if (opMask == `SEPA_OP_SETWEL || opMask == `SEPA_OP_CLRWEL) st_ff <= S_DEAD;
                                else if (opMask == `SEPA_OP_WRSTAT) begin
                                    st_ff <= S_WDAT; byteCnt_ff <= 2'h0;
                                end else if (opMask != `SEPA_OP_READ && opMask != `SEPA_OP_WRITE) st_ff <= S_DEAD;
                            end else begin
                                addr_ff <= {addr_ff[AW-9:0], byteIn};                    // RULE_08
                                byteCnt_ff <= byteCnt_ff + 2'h1;
                                if (byteCnt_ff == 2'h2) begin
                                    byteCnt_ff <= 2'h0;
                                    if (op_ff == `SEPA_OP_READ) begin
                                        st_ff <= S_RDAT; loadTx_ff <= 1'b1;              // RULE_03 RULE_04
                                    end else st_ff <= S_WDAT;
                                end
                            end
                        end
                        S_WDAT: begin
                            if (op_ff == `SEPA_OP_WRSTAT) begin
                                // Only the first data byte counts; it is applied when select rises
                                if (byteCnt_ff == 2'h0) stNew_ff <= byteIn;
                                byteCnt_ff <= 2'h1;
                            end else begin
                                byteCnt_ff <= 2'h1;
                                addr_ff[PW-1:0] <= addr_ff[PW-1:0] + 1'b1;               // RULE_16 RULE_17
                            end
                        end
                        S_RDAT: begin
                            addr_ff <= addr_ff + 1'b1;                                   // RULE_06 RULE_07
                            loadTx_ff <= 1'b1;
                        end
                        default: ;
                    endcase
                end
            end else if (sckFall && (st_ff == S_RDAT || st_ff == S_STAT)) begin
                // Data changes on the falling edge, MSB first
                spiSo_ff <= txByte_ff[7 - bitCnt_ff];                                    // RULE_04 RULE_25
                if (st_ff == S_STAT && bitCnt_ff == 3'h7) txByte_ff <= statusByte;
            end
        end
    end

    // Page buffer capture during write data phase
    always @(posedge ref_clk) begin
        if (ce && byteEnd && st_ff == S_WDAT && op_ff == `SEPA_OP_WRITE) begin
            page_ff[addr_ff[PW-1:0]] <= byteIn;                                          // RULE_17
        end
    end

    // Self-timed program cycle, write latch and nonvolatile status bits
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            pst_ff <= P_IDLE; progIdx_ff <= {(PW+1){1'b0}}; twc_ff <= 32'h0;
            wel_ff <= 1'b0; pen_ff <= 1'b0; bph_ff <= 1'b0; bpl_ff <= 1'b0;
        end else if (ce) begin
            if (byteEnd && st_ff == S_ADDR && op_ff == 8'h00 && !busy) begin
                if (opMask == `SEPA_OP_SETWEL) wel_ff <= 1'b1;
                if (opMask == `SEPA_OP_CLRWEL) wel_ff <= 1'b0;
            end
            case (pst_ff)
                P_IDLE: begin
                    if (wrPend_ff) begin
                        pst_ff <= P_PROG; progIdx_ff <= {(PW+1){1'b0}};
                    end else if (stPend_ff) begin
                        {pen_ff, bph_ff, bpl_ff} <= {stNew_ff[`SEPA_ST_PEN], stNew_ff[`SEPA_ST_BPH],
                                                     stNew_ff[`SEPA_ST_BPL]};
                        pst_ff <= P_WAIT; twc_ff <= 32'h0;
                    end
                end
                P_PROG: begin
                    // Whole page copied, then the timed wait models the cell program time
                    progIdx_ff <= progIdx_ff + 1'b1;
                    if (progIdx_ff[PW-1:0] == {PW{1'b1}}) begin
                        pst_ff <= P_WAIT; twc_ff <= 32'h0;
                    end
                end
                P_WAIT: begin
                    twc_ff <= twc_ff + 32'h1;
                    if (twc_ff >= TWC_CYC - 1) begin
                        pst_ff <= P_IDLE;
                        wel_ff <= 1'b0;                                                  // RULE_18
                    end
                end
                default: pst_ff <= P_IDLE;
            endcase
        end
    end
endmodule // sepa_top
`default_nettype wire

/* sepa_top_monitor.sv */
// Port-level checker for the serial EEPROM page-access block
`timescale 1ns/1ps
`default_nettype none
module sepa_top_monitor #(
    parameter TWC_CYC = 20
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic spiCsB,
    input wire logic spiSck,
    input wire logic spiSi,
    input wire logic protectPinB,
    input wire logic spiSo_ff,
    input wire logic spiSoOeB,
    input wire logic busy
);
    int busyLen_ff;

    // Busy length; cycles with ce low are not counted since the design is frozen then
    always @(posedge ref_clk) begin
        if (!rst_b || !busy) busyLen_ff <= 0;
        else if (ce) busyLen_ff <= busyLen_ff + 1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_reset_idle: assert property ($rose(rst_b) |-> !busy && spiSoOeB)
        else $error("busy or output enabled right after reset");
    a_busy_min_len: assert property ($fell(busy) |-> busyLen_ff >= TWC_CYC)
        else $error("program cycle ended early");
    a_busy_max_len: assert property (busy |-> busyLen_ff <= TWC_CYC + 130)
        else $error("program cycle runs too long");
    a_busy_start: assert property ($rose(busy) |-> spiCsB && $past(spiCsB, 2))
        else $error("program cycle started while selected");
    a_so_on_fall: assert property ($changed(spiSo_ff) && !spiSoOeB |-> !$past(spiSck))
        else $error("serial output moved outside clock low phase");
    a_oe_on_fall: assert property ($fell(spiSoOeB) |-> !spiCsB && !spiSck)
        else $error("output enabled outside a selected low phase");
    a_oe_deselected: assert property (spiCsB [*5] |-> spiSoOeB)
        else $error("output enabled while deselected");
    a_ce_freeze: assert property (!ce |=> $stable(busy) && $stable(spiSo_ff))
        else $error("state moved with clock enable low");

    cover property ($rose(busy));
    cover property ($fell(spiSoOeB));
    cover property ($fell(busy) && busyLen_ff > TWC_CYC + 64);
endmodule // sepa_top_monitor

bind sepa_top sepa_top_monitor #(.TWC_CYC(TWC_CYC)) u_mon (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
    .spiCsB(spiCsB), .spiSck(spiSck), .spiSi(spiSi), .protectPinB(protectPinB), .spiSo_ff(spiSo_ff),
    .spiSoOeB(spiSoOeB), .busy(busy));
`default_nettype wire

/* sepa_master.sv */
// Mode 0 SPI master model facing the EEPROM block
`timescale 1ns/1ps
`default_nettype none
module sepa_master (
    input  wire logic ref_clk,
    output var  logic spiCsB,
    output var  logic spiSck,
    output var  logic spiSi,
    input  wire logic spiSo_ff,
    input  wire logic spiSoOeB
);
    logic flip;
    wire  soLine;

    initial begin
        spiCsB = 1'b1;
        spiSck = 1'b0;
        spiSi = 1'b0;
        flip = 1'b0;
    end

    // A released output shows a changing pattern so a stale bit never passes
    always @(posedge ref_clk) flip <= ~flip;
    assign soLine = spiSoOeB ? flip : spiSo_ff;

    // Half of a 200 ns link clock period
    task automatic waitHalf();
        repeat (4) @(negedge ref_clk);
    endtask

    // Select changes only with the link clock low
    task automatic sel(input logic on);
        waitHalf();
        spiCsB = !on;
        waitHalf();
    endtask

    // One byte each way, most significant bit first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spiSi = tx[i];
            waitHalf();
            rx[i] = soLine;
            spiSck = 1'b1;
            waitHalf();
            spiSck = 1'b0;
        end
    endtask
endmodule // sepa_master
`default_nettype wire

/* tb.sv */
// Self-checking bench for the serial EEPROM page-access block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TWC = 20;
    logic        ref_clk = 1'b0;
    logic        rst_b;
    logic        ce;
    logic        protectPinB;
    wire         spiCsB, spiSck, spiSi, spiSo_ff, spiSoOeB, busy;
    int          fails = 0;
    int          checks = 0;
    logic [7:0]  r, st;
    logic [7:0]  cont [4] = '{8'hbc, 8'hbd, 8'h69, 8'h68};
    // Opcode, address, expected byte
    logic [39:0] rows [5] = '{{8'h03, 24'hfffffe, 8'hbc}, {8'h0b, 24'h01ff80, 8'h3e},
        {8'h03, 24'h7e0001, 8'h68}, {8'h0b, 24'h01fffd, 8'h43}, {8'h03, 24'h000000, 8'h69}};

    always #12.5 ref_clk = ~ref_clk;

    sepa_top #(.TWC_CYC(TWC)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .spiCsB(spiCsB), .spiSck(spiSck),
        .spiSi(spiSi), .protectPinB(protectPinB), .spiSo_ff(spiSo_ff), .spiSoOeB(spiSoOeB), .busy(busy));
    sepa_master mst (.ref_clk(ref_clk), .spiCsB(spiCsB), .spiSck(spiSck), .spiSi(spiSi), .spiSo_ff(spiSo_ff),
        .spiSoOeB(spiSoOeB));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op1(input logic [7:0] op);
        mst.sel(1'b1);
        mst.xfer(op, r);
        mst.sel(1'b0);
    endtask
    // Opcode and three address bytes; the frame stays open
    task automatic hdr(input logic [7:0] op, input logic [23:0] a);
        mst.sel(1'b1);
        mst.xfer(op, r);
        for (int i = 2; i >= 0; i--) mst.xfer(a[8*i +: 8], r);
    endtask
    // Single-byte read; junk on the input after the address must not matter
    task automatic rd1(input logic [7:0] op, input logic [23:0] a);
        hdr(op, a);
        mst.xfer(8'ha5, r);
        mst.sel(1'b0);
    endtask
    task automatic stWr(input logic [7:0] v);
        op1(8'h06);
        mst.sel(1'b1);
        mst.xfer(8'h01, r);
        mst.xfer(v, r);
        mst.sel(1'b0);
    endtask
    task automatic rdStat();
        mst.sel(1'b1);
        mst.xfer(8'h05, st);
        mst.xfer(8'h00, st);
        mst.sel(1'b0);
    endtask
    task automatic waitIdle();
        st = 8'h01;
        for (int k = 0; k < 8 && st[0] !== 1'b0; k++) rdStat();
    endtask
    task automatic pageWr(input logic [23:0] a, input int n, input logic [7:0] key, input logic wel);
        if (wel) op1(8'h06);
        hdr(8'h02, a);
        for (int i = 0; i < n; i++) mst.xfer(8'(i) ^ key, r);
        mst.sel(1'b0);
    endtask
    task automatic conclude();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        protectPinB = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        check({6'h0, busy, spiSoOeB}, 8'h01);
        rdStat();
        check(st, 8'h00);
        pageWr(24'hfffffe, 130, 8'h3c, 1'b1);
        rdStat();
        check(st, 8'hff);
        waitIdle();
        check(st, 8'h00);
        pageWr(24'h000000, 128, 8'h69, 1'b1);
        // Read refused while programming: the output must stay released
        hdr(8'h03, 24'h000000);
        mst.xfer(8'h00, r);
        check({7'h0, spiSoOeB}, 8'h01);
        mst.sel(1'b0);
        waitIdle();
        check(st, 8'h00);
        for (int i = 0; i < 5; i++) begin
            rd1(rows[i][39:32], rows[i][31:8]);
            check(r, rows[i][7:0]);
        end
        // Continuous read across the top of the array
        hdr(8'h03, 24'h01fffe);
        for (int i = 0; i < 4; i++) begin
            mst.xfer(8'h5a, r);
            check(r, cont[i]);
        end
        mst.sel(1'b0);
        // Write without the latch must be dropped
        pageWr(24'h000000, 128, 8'h00, 1'b0);
        repeat (8) @(negedge ref_clk);
        check({7'h0, busy}, 8'h00);
        rd1(8'h03, 24'h000000);
        check(r, 8'h69);
        stWr(8'h8c);
        // Freeze the status program cycle for a few clocks
        repeat (6) @(negedge ref_clk);
        ce = 1'b0;
        repeat (3) @(negedge ref_clk);
        ce = 1'b1;
        check({7'h0, busy}, 8'h01);
        waitIdle();
        check(st, 8'h8c);
        protectPinB = 1'b0;
        stWr(8'h00);
        rdStat();
        check(st, 8'h8e);
        pageWr(24'h000000, 128, 8'hff, 1'b1);
        waitIdle();
        rd1(8'h03, 24'h000000);
        check(r, 8'h69);
        protectPinB = 1'b1;
        stWr(8'h00);
        waitIdle();
        check(st, 8'h00);
        conclude();
    end

    // Hang guard sized well above the longest expected run
    initial begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        conclude();
    end
endmodule // tb
`default_nettype wire
